// [logic/ubp_user_bit_port.sv]
`timescale 1ns/100ps

module ubp_user_bit_port
  import ubp_pkg::*;
#(
  parameter int unsigned TENTH_DIV = TENTH_CYCLES,
  parameter int unsigned FRAME_DIV = FRAME_CYCLES,
  parameter int          BOARDS    = RELAY_BOARDS
) (
  input  wire logic                  clock_in,         // 100 MHz clock
  input  wire logic                  rst_in,           // async reset
  input  wire logic                  gen_running_in,   // generator running
  input  wire logic                  frame_start_in,   // generated frame start
  input  wire logic                  record_en_in,     // record option
  input  wire ubp_pb_mode_t          pb_mode_in,       // playback option
  input  wire logic                  autorest_en_in,   // auto-rest enable
  input  wire logic [7:0]            freewheel_in,     // freewheel, frames
  input  wire ubp_rx_t               rx_in,            // received frame
  input  wire logic                  cmd_valid_in,     // script command strobe
  input  wire ubp_cmd_t              cmd_in,           // script command
  input  wire logic [UB_W-1:0]       pin_in,           // ports 1-4 pin levels
  output logic [PIN_W-1:0]           port_out,         // pin drive levels
  output logic [PIN_W-1:0]           port_oe_n_out,    // low while driving
  output logic [UB_W-1:0]            ub_record_out,    // user bits to insert
  output logic                       ub_record_stb_out,// capture pulse
  output logic                       ub_insert_out,    // replace user bits
  output logic                       playing_out,      // playback engaged
  output logic [7:0]                 read_data_out,    // port read value
  output logic                       read_valid_out,   // read data pulse
  output logic [BOARDS*PORT_W-1:0]   relay_out         // relay coils, high on
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [NUM_PORTS-1:0] port_mask(input ubp_cmd_t c);
    logic [NUM_PORTS-1:0] m;
    m = '0;
    for (int p = 0; p < NUM_PORTS; p++)
      m[p] = c.port_all || (c.port == 3'(p));
    return m;
  endfunction : port_mask

  function automatic logic [PIN_W-1:0] bit_mask(input ubp_cmd_t c);
    logic [PIN_W-1:0]     m;
    logic [NUM_PORTS-1:0] pm;
    m  = '0;
    pm = port_mask(c);
    for (int i = 0; i < PIN_W; i++)
      m[i] = pm[i / PORT_W] && (c.bit_all || (c.bit_no == 3'(i % PORT_W)));
    return m;
  endfunction : bit_mask

  function automatic logic [PIN_W-1:0] widen(input logic [NUM_PORTS-1:0] p);
    logic [PIN_W-1:0] m;
    m = '0;
    for (int i = 0; i < PIN_W; i++)
      m[i] = p[i / PORT_W];
    return m;
  endfunction : widen

  // ---------------------------------------------------------------
  // rate enables and pin inputs
  // ---------------------------------------------------------------
  logic            tenth_tick;
  logic            frame_tick;
  logic [UB_W-1:0] pin_sync;

  ubp_divider #(.DIV(TENTH_DIV)) u_tenth (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .clear_in (1'b0),
    .tick_out (tenth_tick)
  );

  ubp_pin_sync #(.W(UB_W)) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .pin_in   (pin_in),
    .pin_out  (pin_sync)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PIN_W-1:0]     act;
  logic [UB_W-1:0]      hold;
  logic [NUM_PORTS-1:0] port_en;
  logic                 playing;
  logic [7:0]           fw_count;
  logic [UB_W-1:0]      last_ub;
  logic [7:0]           pulse_left [PIN_W];

  logic [PIN_W-1:0]     next_act;
  logic [UB_W-1:0]      next_hold;
  logic [NUM_PORTS-1:0] next_port_en;
  logic                 next_playing;
  logic [7:0]           next_fw_count;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire pb_on      = (pb_mode_in != UBP_PB_OFF);
  wire valid_fr   = rx_in.done && rx_in.ok && pb_on;
  wire cmd_take   = cmd_valid_in && (pb_mode_in != UBP_PB_USER);
  wire capture    = frame_start_in && gen_running_in
                    && record_en_in;
  wire [PIN_W-1:0]     sel      = bit_mask(cmd_in);
  wire [NUM_PORTS-1:0] psel     = port_mask(cmd_in);
  wire [PIN_W-1:0]     pwide    = widen(psel);
  wire [PIN_W-1:0]     data_rep = {NUM_PORTS{cmd_in.data}};
  wire [7:0]           pulse_len = (cmd_in.data == 8'h00)
                                   ? PULSE_DEFAULT_TENTHS : cmd_in.data;
  wire is_write = cmd_take && (cmd_in.op == UBP_PORT_BYTE_WRITE_COMMAND);
  wire is_on    = cmd_take && (cmd_in.op == UBP_BIT_ACTIVATE_COMMAND);
  wire is_off   = cmd_take && (cmd_in.op == UBP_BIT_DEACTIVATE_COMMAND);
  wire is_pulse = cmd_take && (cmd_in.op == UBP_BIT_PULSE_COMMAND);
  wire is_hold  = cmd_take && (cmd_in.op == UBP_HOLD_BIT_COMMAND);
  wire is_rel   = cmd_take && (cmd_in.op == UBP_RELEASE_BIT_COMMAND);
  wire is_read  = cmd_take && (cmd_in.op == UBP_PORT_READ_COMMAND)
                  && !cmd_in.port_all && (cmd_in.port < 3'(IN_PORTS));
  wire bit_cmd  = is_on || is_off || is_pulse;
  wire [PIN_W-1:0] touched = is_write ? pwide : (bit_cmd ? sel : '0);

  logic [PIN_W-1:0] expire;
  always_comb
  begin
    for (int i = 0; i < PIN_W; i++)
      expire[i] = tenth_tick && (pulse_left[i] == 8'h01);
  end

  wire fw_over = playing && frame_tick && autorest_en_in
                 && (fw_count >= freewheel_in);

  ubp_divider #(.DIV(FRAME_DIV)) u_frame (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .clear_in (valid_fr),
    .tick_out (frame_tick)
  );

  // ---------------------------------------------------------------
  // next state: frame, then timers, then script (script wins)
  // ---------------------------------------------------------------
  always_comb
  begin
    next_act      = act;
    next_hold     = hold;
    next_port_en  = port_en;
    next_playing  = playing;
    next_fw_count = fw_count;
    if (valid_fr)
    begin
      next_playing  = 1'b1;
      next_fw_count = 8'h00;
      next_port_en  = port_en | OUT_PORTS_MASK;
      for (int i = 0; i < UB_W; i++)
        if (!hold[i])
          next_act[OUT_BIT_BASE+i] = rx_in.bits[i];
    end
    else if (fw_over)
    begin
      next_playing = 1'b0;
      for (int i = 0; i < UB_W; i++)
        if (!hold[i])
          next_act[OUT_BIT_BASE+i] = 1'b0;
    end
    else if (playing && frame_tick && fw_count != 8'hFF)
      next_fw_count = fw_count + 8'h01;
    if (!pb_on)
      next_playing = 1'b0;
    next_act = next_act & ~expire;
    if (is_write)
      next_act = (next_act & ~pwide) | (data_rep & pwide);
    if (is_on || is_pulse)
      next_act = next_act | sel;
    if (is_off)
      next_act = next_act & ~sel;
    if (is_write || bit_cmd)
    begin
      next_port_en = next_port_en | psel;
      next_hold    = next_hold | touched[PIN_W-1:OUT_BIT_BASE];
    end
    if (is_hold)
      next_hold = next_hold | sel[PIN_W-1:OUT_BIT_BASE];
    if (is_rel)
    begin
      next_hold = next_hold & ~sel[PIN_W-1:OUT_BIT_BASE];
      if (playing)
        for (int i = 0; i < UB_W; i++)
          if (sel[OUT_BIT_BASE+i])
            next_act[OUT_BIT_BASE+i] = last_ub[i];
    end
    if (is_read)
      next_port_en[cmd_in.port] = 1'b0;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      act      <= '0;
      hold     <= '0;
      port_en  <= PORT_EN_RESET;
      playing  <= 1'b0;
      fw_count <= 8'h00;
      last_ub  <= '0;
    end
    else
    begin
      act      <= next_act;
      hold     <= next_hold;
      port_en  <= next_port_en;
      playing  <= next_playing;
      fw_count <= next_fw_count;
      if (valid_fr)
        last_ub <= rx_in.bits;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < PIN_W; i++)
        pulse_left[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < PIN_W; i++)
        if (is_pulse && sel[i])
          pulse_left[i] <= pulse_len;
        else if (touched[i])
          pulse_left[i] <= 8'h00;
        else if (tenth_tick && pulse_left[i] != 8'h00)
          pulse_left[i] <= pulse_left[i] - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // pins and relays
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      port_out      <= PIN_LEVEL_RESET;
      port_oe_n_out <= PIN_OE_N_RESET;
      relay_out     <= '0;
      playing_out   <= 1'b0;
    end
    else
    begin
      port_out      <= ~next_act;
      port_oe_n_out <= ~widen(next_port_en);
      relay_out     <= next_act[PIN_W-1 -: BOARDS*PORT_W];
      playing_out   <= next_playing;
    end
  end

  // ---------------------------------------------------------------
  // record capture and port read
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ub_record_out     <= '0;
      ub_record_stb_out <= 1'b0;
      ub_insert_out     <= 1'b0;
      read_data_out     <= 8'h00;
      read_valid_out    <= 1'b0;
    end
    else
    begin
      ub_insert_out     <= record_en_in && gen_running_in;
      ub_record_stb_out <= capture;
      if (capture)
        ub_record_out <= ~pin_sync;
      read_valid_out <= is_read;
      if (is_read)
        read_data_out <= pin_sync[cmd_in.port[1:0]*PORT_W +: PORT_W];
    end
  end

endmodule : ubp_user_bit_port

// [shared/ubp_pkg.sv]
package ubp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int NUM_PORTS     = 8;
  localparam int PORT_W        = 8;
  localparam int PIN_W         = NUM_PORTS * PORT_W;
  localparam int UB_W          = 32;
  localparam int IN_PORTS      = 4;
  localparam int OUT_BIT_BASE  = 32;
  localparam int RELAY_BOARDS  = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS   = 10;
  localparam int TENTH_TIME_NS     = 100_000_000;
  localparam int TENTH_CYCLES      = TENTH_TIME_NS / CLOCK_PERIOD_NS;
  localparam int FRAME_TIME_NS     = 33_333_333;
  localparam int FRAME_CYCLES      = FRAME_TIME_NS / CLOCK_PERIOD_NS;
  localparam logic [7:0] PULSE_DEFAULT_TENTHS = 8'h05;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [PIN_W-1:0] PIN_LEVEL_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [PIN_W-1:0] PIN_OE_N_RESET  = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0]       PORT_EN_RESET   = 8'h00;
  localparam logic [7:0]       OUT_PORTS_MASK  = 8'hF0;

  typedef enum logic [1:0] {
    UBP_PB_OFF,
    UBP_PB_USER,
    UBP_PB_USER_SCRIPT
  } ubp_pb_mode_t;

  typedef enum logic [2:0] {
    UBP_PORT_BYTE_WRITE_COMMAND,
    UBP_BIT_ACTIVATE_COMMAND,
    UBP_BIT_DEACTIVATE_COMMAND,
    UBP_BIT_PULSE_COMMAND,
    UBP_HOLD_BIT_COMMAND,
    UBP_RELEASE_BIT_COMMAND,
    UBP_PORT_READ_COMMAND
  } ubp_op_t;

  typedef struct packed {
    ubp_op_t    op;
    logic       port_all;
    logic [2:0] port;
    logic       bit_all;
    logic [2:0] bit_no;
    logic [7:0] data;
  } ubp_cmd_t;

  typedef struct packed {
    logic            done;
    logic            ok;
    logic [UB_W-1:0] bits;
  } ubp_rx_t;

endpackage : ubp_pkg

// [logic/ubp_divider.sv]
`timescale 1ns/100ps

// one-cycle enable every DIV clocks, restartable
module ubp_divider #(
  parameter int unsigned DIV = 10
) (
  input  wire logic clock_in,  // system clock
  input  wire logic rst_in,    // async reset
  input  wire logic clear_in,  // restart the period
  output logic      tick_out   // one-cycle enable
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  wire           wrap = (count == LAST);

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count    <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      count    <= (clear_in || wrap) ? '0 : count + CW'(1);
      tick_out <= wrap && !clear_in;
    end
  end

endmodule : ubp_divider

// [logic/ubp_pin_sync.sv]
`timescale 1ns/100ps

// three-stage synchroniser; a bit changes once stages two and three agree
module ubp_pin_sync #(
  parameter int W = 32
) (
  input  wire logic         clock_in,  // system clock
  input  wire logic         rst_in,    // async reset
  input  wire logic [W-1:0] pin_in,    // asynchronous pins
  output logic      [W-1:0] pin_out    // settled pin levels
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1  <= '1;
      stage2  <= '1;
      stage3  <= '1;
      pin_out <= '1;
    end
    else
    begin
      stage1  <= pin_in;
      stage2  <= stage1;
      stage3  <= stage2;
      pin_out <= (agree & stage3) | (~agree & pin_out);
    end
  end

endmodule : ubp_pin_sync

// [verif/ubp_user_bit_port_chk.sv]
`timescale 1ns/100ps

module ubp_user_bit_port_chk
  import ubp_pkg::*;
#(
  parameter int BOARDS = RELAY_BOARDS
) (
  input wire logic                     clock_in,          // clock
  input wire logic                     rst_in,            // reset
  input wire logic                     gen_running_in,    // generator on
  input wire logic                     frame_start_in,    // frame start
  input wire logic                     record_en_in,      // record option
  input wire ubp_pb_mode_t             pb_mode_in,        // playback option
  input wire logic                     autorest_en_in,    // auto-rest
  input wire ubp_rx_t                  rx_in,             // received frame
  input wire logic                     cmd_valid_in,      // command strobe
  input wire ubp_cmd_t                 cmd_in,            // command
  input wire logic [PIN_W-1:0]         port_out,          // pin levels
  input wire logic [PIN_W-1:0]         port_oe_n_out,     // pin enables
  input wire logic [UB_W-1:0]          ub_record_out,     // captured bits
  input wire logic                     ub_record_stb_out, // capture pulse
  input wire logic                     ub_insert_out,     // insert level
  input wire logic                     playing_out,       // playback on
  input wire logic                     read_valid_out,    // read pulse
  input wire logic [BOARDS*PORT_W-1:0] relay_out          // relay coils
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  property p_rec_stb;
    frame_start_in && gen_running_in && record_en_in |=> ub_record_stb_out;
  endproperty
  a_rec_stb: assert property (p_rec_stb)
    else $error("no capture pulse after frame start");

  property p_rec_hold;
    $changed(ub_record_out) |-> ub_record_stb_out;
  endproperty
  a_rec_hold: assert property (p_rec_hold)
    else $error("captured bits moved without a capture");

  property p_no_rec;
    !record_en_in |=> !ub_record_stb_out;
  endproperty
  a_no_rec: assert property (p_no_rec)
    else $error("capture while record is off");

  property p_insert;
    1'b1 |=> ub_insert_out == $past(record_en_in && gen_running_in);
  endproperty
  a_insert: assert property (p_insert)
    else $error("insert level does not follow record and run");

  property p_engage;
    rx_in.done && rx_in.ok && pb_mode_in != UBP_PB_OFF
      |=> playing_out && port_oe_n_out[PIN_W-1:OUT_BIT_BASE] == '0;
  endproperty
  a_engage: assert property (p_engage)
    else $error("valid frame did not engage playback");

  property p_bad_frame;
    rx_in.done && !rx_in.ok && !playing_out |=> !playing_out;
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("bad frame engaged playback");

  property p_off;
    pb_mode_in == UBP_PB_OFF |=> !playing_out;
  endproperty
  a_off: assert property (p_off)
    else $error("playing while playback is off");

  property p_rest;
    playing_out && !autorest_en_in && pb_mode_in != UBP_PB_OFF
      |=> playing_out;
  endproperty
  a_rest: assert property (p_rest)
    else $error("playback dropped without auto-rest");

  property p_out_stay;
    ($past(~port_oe_n_out[PIN_W-1:OUT_BIT_BASE])
      & port_oe_n_out[PIN_W-1:OUT_BIT_BASE]) == '0;
  endproperty
  a_out_stay: assert property (p_out_stay)
    else $error("output port left the driven state");

  property p_read_out;
    cmd_valid_in && cmd_in.op == UBP_PORT_READ_COMMAND && cmd_in.port[2]
      |=> !read_valid_out;
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read answered on an output port");

  property p_relay;
    relay_out == ~port_out[PIN_W-1 -: BOARDS*PORT_W];
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay coils differ from top ports");
endmodule : ubp_user_bit_port_chk

bind ubp_user_bit_port ubp_user_bit_port_chk #(.BOARDS(BOARDS))
  ubp_user_bit_port_chk_i (.clock_in, .rst_in, .gen_running_in,
  .frame_start_in, .record_en_in, .pb_mode_in, .autorest_en_in, .rx_in,
  .cmd_valid_in, .cmd_in, .port_out, .port_oe_n_out, .ub_record_out,
  .ub_record_stb_out, .ub_insert_out, .playing_out, .read_valid_out,
  .relay_out);

// [verif/ubp_deck_model.sv]
`timescale 1ns/100ps

// tape deck side: one decoded frame FL cycles after a send request
module ubp_deck_model
  import ubp_pkg::*;
#(
  parameter int FL = 10
) (
  input  wire logic            clock_in, // clock
  input  wire logic            send_in,  // start one frame
  input  wire logic            ok_in,    // frame decodes cleanly
  input  wire logic [UB_W-1:0] bits_in,  // user bits carried
  output ubp_rx_t              rx_out    // decoded frame
);
  int              cnt = 0;
  logic            ok;
  logic [UB_W-1:0] bits;

  always @(posedge clock_in)
  begin
    // off the strobe the fields toggle, so stale values are never usable
    rx_out.done <= 1'b0;
    rx_out.ok   <= ~rx_out.ok;
    rx_out.bits <= ~rx_out.bits;
    if (send_in)
    begin
      ok   <= ok_in;
      bits <= bits_in;
      cnt  <= FL;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
        rx_out <= '{1'b1, ok, bits};
    end
  end
endmodule : ubp_deck_model

// [verif/tb_ubp_user_bit_port.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_ubp_user_bit_port
  import ubp_pkg::*;
;
  localparam int FL = 10;
  logic clock_in, rst_in, gen_running_in, frame_start_in, record_en_in;
  logic autorest_en_in, cmd_valid_in, send, sok, rd_seen;
  logic ub_record_stb_out, ub_insert_out, playing_out, read_valid_out;
  ubp_pb_mode_t     pb_mode_in;
  ubp_rx_t          rx_in;
  ubp_cmd_t         cmd_in;
  logic [7:0]       freewheel_in, rd_byte, read_data_out;
  logic [UB_W-1:0]  pin_in, sbits, ub_record_out, relay_out;
  logic [PIN_W-1:0] port_out, port_oe_n_out;
  int               errors = 0, n_compared = 0, t;

  ubp_user_bit_port #(.TENTH_DIV(20), .FRAME_DIV(50), .BOARDS(4))
    ubp_user_bit_port_i (.clock_in, .rst_in, .gen_running_in,
    .frame_start_in, .record_en_in, .pb_mode_in, .autorest_en_in,
    .freewheel_in, .rx_in, .cmd_valid_in, .cmd_in, .pin_in, .port_out,
    .port_oe_n_out, .ub_record_out, .ub_record_stb_out, .ub_insert_out,
    .playing_out, .read_data_out, .read_valid_out, .relay_out);

  ubp_deck_model #(.FL(FL)) ubp_deck_model_i (.clock_in, .send_in(send),
    .ok_in(sok), .bits_in(sbits), .rx_out(rx_in));

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic cmd(input ubp_op_t op, input logic [2:0] p, b,
                     input logic [7:0] d);
    @(posedge clock_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= '{op, 1'b0, p, 1'b0, b, d};
    @(posedge clock_in);
    cmd_valid_in <= 1'b0;
    rd_seen = 1'b0;
    repeat (3)
    begin
      #1;
      if (read_valid_out === 1'b1)
        {rd_seen, rd_byte} = {1'b1, read_data_out};
      @(posedge clock_in);
    end
    #1;
  endtask : cmd

  task automatic frame(input logic ok, input logic [UB_W-1:0] b);
    @(posedge clock_in);
    {send, sok, sbits} <= {1'b1, ok, b};
    @(posedge clock_in);
    send <= 1'b0;
    repeat (FL + 1) @(posedge clock_in);
    #1;
  endtask : frame

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial
  begin
    #100_000;
    errors++;
    give_verdict();
  end

  initial
  begin
    {gen_running_in, frame_start_in, record_en_in, autorest_en_in} = '0;
    {cmd_valid_in, send, sok, sbits, freewheel_in} = '0;
    pb_mode_in = UBP_PB_OFF;
    cmd_in = '0;
    pin_in = '1;
    rst_in = 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    `CHK(port_out, PIN_LEVEL_RESET)
    `CHK(port_oe_n_out, PIN_OE_N_RESET)
    // ------------------------------------------------------------
    // record
    // ------------------------------------------------------------
    @(posedge clock_in);
    {record_en_in, gen_running_in} <= 2'b11;
    pin_in <= 32'h5A3C_0FF0;
    repeat (6) @(posedge clock_in);
    frame_start_in <= 1'b1;
    @(posedge clock_in);
    frame_start_in <= 1'b0;
    #1;
    `CHK(ub_record_stb_out, 1'b1)
    `CHK(ub_record_out, 32'hA5C3_F00F)
    `CHK(ub_insert_out, 1'b1)
    @(posedge clock_in);
    record_en_in <= 1'b0;
    pin_in <= 32'h1234_C3A5;
    repeat (6) @(posedge clock_in);
    frame_start_in <= 1'b1;
    @(posedge clock_in);
    frame_start_in <= 1'b0;
    #1;
    `CHK({ub_record_stb_out, ub_insert_out}, 2'b00)
    `CHK(ub_record_out, 32'hA5C3_F00F)
    $display("test record over");
    // ------------------------------------------------------------
    // playback and held bits
    // ------------------------------------------------------------
    @(posedge clock_in);
    pb_mode_in <= UBP_PB_USER;
    frame(1'b0, 32'hFFFF_FFFF);
    `CHK({playing_out, port_oe_n_out[63:32]}, 33'h0_FFFF_FFFF)
    frame(1'b1, 32'hA5A5_1234);
    `CHK(port_out[63:32], 32'h5A5A_EDCB)
    `CHK({playing_out, port_oe_n_out[63:32]}, 33'h1_0000_0000)
    `CHK(relay_out, 32'h5A5A_EDCB ^ 32'hFFFF_FFFF)
    frame(1'b0, 32'h0000_0000);
    `CHK(port_out[63:32], 32'h5A5A_EDCB)
    @(posedge clock_in);
    pb_mode_in <= UBP_PB_USER_SCRIPT;
    cmd(UBP_BIT_ACTIVATE_COMMAND, 3'd4, 3'd0, 8'h00);
    `CHK(port_out[63:32], 32'h5A5A_EDCA)
    cmd(UBP_HOLD_BIT_COMMAND, 3'd4, 3'd2, 8'h00);
    `CHK(port_out[63:32], 32'h5A5A_EDCA)
    frame(1'b1, 32'h0000_0000);
    `CHK(port_out[63:32], 32'hFFFF_FFFA)
    cmd(UBP_RELEASE_BIT_COMMAND, 3'd4, 3'd0, 8'h00);
    `CHK(port_out[63:32], 32'hFFFF_FFFB)
    cmd(UBP_BIT_DEACTIVATE_COMMAND, 3'd4, 3'd2, 8'h00);
    frame(1'b1, 32'h0000_0004);
    `CHK(port_out[63:32], 32'hFFFF_FFFF)
    cmd(UBP_RELEASE_BIT_COMMAND, 3'd4, 3'd2, 8'h00);
    `CHK(port_out[63:32], 32'hFFFF_FFFB)
    cmd(UBP_PORT_BYTE_WRITE_COMMAND, 3'd5, 3'd0, 8'h81);
    frame(1'b1, 32'h0000_0000);
    `CHK(port_out[63:32], 32'hFFFF_7EFF)
    cmd(UBP_BIT_PULSE_COMMAND, 3'd7, 3'd7, 8'h02);
    `CHK(port_out[63:32], 32'h7FFF_7EFF)
    t = 0;
    while (port_out[63] !== 1'b1 && t < 100)
    begin
      @(posedge clock_in);
      #1;
      t++;
    end
    `CHK(t > 12 && t < 60, 1'b1)
    $display("test playback over");
    // ------------------------------------------------------------
    // ports 1-4
    // ------------------------------------------------------------
    cmd(UBP_PORT_BYTE_WRITE_COMMAND, 3'd0, 3'd0, 8'hC3);
    `CHK({port_out[7:0], port_oe_n_out[7:0]}, 16'h3C00)
    cmd(UBP_PORT_READ_COMMAND, 3'd1, 3'd0, 8'h00);
    `CHK({rd_seen, rd_byte, port_oe_n_out[15:8]}, 17'h1_C3FF)
    cmd(UBP_PORT_READ_COMMAND, 3'd4, 3'd0, 8'h00);
    `CHK(rd_seen, 1'b0)
    $display("test ports over");
    // ------------------------------------------------------------
    // auto-rest
    // ------------------------------------------------------------
    @(posedge clock_in);
    {autorest_en_in, freewheel_in} <= {1'b1, 8'h02};
    frame(1'b1, 32'h0000_00FF);
    `CHK(port_out[63:32], 32'hFFFF_7E00)
    t = 0;
    while (playing_out === 1'b1 && t < 300)
    begin
      @(posedge clock_in);
      #1;
      t++;
    end
    `CHK(t > 88 && t < 170, 1'b1)
    `CHK({playing_out, port_out[63:32]}, 33'h0_FFFF_7EFF)
    `CHK(port_oe_n_out[63:32], 32'h0000_0000)
    $display("test auto-rest over");
    // ------------------------------------------------------------
    // playback modes and default pulse
    // ------------------------------------------------------------
    @(posedge clock_in);
    pb_mode_in <= UBP_PB_USER;
    cmd(UBP_BIT_ACTIVATE_COMMAND, 3'd7, 3'd0, 8'h00);
    `CHK(port_out[63:56], 8'hFF)
    frame(1'b1, 32'h0000_0000);
    `CHK(playing_out, 1'b1)
    @(posedge clock_in);
    pb_mode_in <= UBP_PB_OFF;
    @(posedge clock_in);
    #1;
    `CHK(playing_out, 1'b0)
    cmd(UBP_BIT_PULSE_COMMAND, 3'd6, 3'd0, 8'h00);
    `CHK(port_out[48], 1'b0)
    t = 0;
    while (port_out[48] !== 1'b1 && t < 300)
    begin
      @(posedge clock_in);
      #1;
      t++;
    end
    `CHK(t > 77 && t < 98, 1'b1)
    $display("test modes over");
    give_verdict();
  end
endmodule : tb_ubp_user_bit_port
